/* File: design/rate_generator.sv */
// 16-bit divisor counter producing the transmitter rate enable
`timescale 1ns/1ps
`default_nettype none

module rate_generator
  import uart_regs_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // divisor in, tick out
  rate_if.gen       rate
);

  divisor_type cnt_q;
  logic        tick_q;

  // a zero divisor parks the counter; a shrunk divisor wraps at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (rate.divisor == '0) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q >= rate.divisor - 16'h0001) begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  assign rate.tick = tick_q;

endmodule

`default_nettype wire

/* File: design/rate_if.sv */
// link between the register file and the bit-rate generator
`timescale 1ns/1ps
`default_nettype none

interface rate_if;
  import uart_regs_pkg::*;
  divisor_type divisor;
  logic        tick;

  modport gen  (input divisor, output tick);
  modport user (output divisor, input tick);
endinterface

`default_nettype wire

/* File: design/uart_regs_cfg.svh */
// register addresses, field positions, reset values and counts of the port
`ifndef UART_REGS_CFG_SVH
`define UART_REGS_CFG_SVH

`define ADDR_DATA       3'h0
`define ADDR_MASK       3'h1
`define ADDR_STATUS     3'h2
`define ADDR_LINE_FMT   3'h3
`define ADDR_MODEM_CTL  3'h4
`define ADDR_LINE_STAT  3'h5
`define ADDR_MODEM_STAT 3'h6
`define ADDR_SCRATCH    3'h7

`define LCR_DIV_BIT     7
`define LCR_ENH_VALUE   8'hbf
`define EFR_ENH_BIT     4
`define FCR_EN_BIT      0
`define FCR_RXRST_BIT   1
`define FCR_TXRST_BIT   2
`define FCR_TRIG_MSB    7
`define FCR_TRIG_LSB    6
`define IER_RXD_BIT     0
`define IER_TXE_BIT     1
`define IER_RLS_BIT     2
`define IER_MS_BIT      3
`define MCR_DTR_BIT     0
`define MCR_RTS_BIT     1
`define MCR_LOOP_BIT    4

`define IER_ENH_MASK    8'hf0
`define FCR_ENH_MASK    8'h30
`define MCR_ENH_MASK    8'he4
`define IER_BASE_MASK   8'h0f
`define FCR_BASE_MASK   8'hcf
`define MCR_BASE_MASK   8'h1b

`define RST_BYTE        8'h00
`define ZERO_DIV        8'h00

`define RX_DEPTH        16
`define RX_PTR_W        4
`define RX_CNT_W        5
`define RX_ONE          5'h01
`define RX_FULL         5'h10
`define TRIG_LEVEL_0    5'h01
`define TRIG_LEVEL_1    5'h04
`define TRIG_LEVEL_2    5'h08
`define TRIG_LEVEL_3    5'h0e

`endif

/* File: design/uart_regs_pkg.sv */
// shared types of the serial port register file
package uart_regs_pkg;

  // low nibble of the interrupt status byte, per source
  typedef enum logic [3:0] {
    SRC_NONE  = 4'b0001,
    SRC_LINE  = 4'b0110,
    SRC_RXD   = 4'b0100,
    SRC_TXE   = 4'b0010,
    SRC_MODEM = 4'b0000
  } irq_source_type;

  typedef logic [7:0]  byte_type;
  typedef logic [15:0] divisor_type;

endpackage

/* File: design/uart_regs_top.sv */
// host register file, receive queue and rate generator of the serial port
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs_cfg.svh"

module uart_regs_top
  import uart_regs_pkg::*;
#(
  parameter byte_type REV_CODE   = 8'h5a, // arbitrary value
  parameter byte_type IDENT_CODE = 8'h3c  // arbitrary value
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // host parallel bus pins
  input  wire logic        cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [7:0]  data_i,
  output logic      [7:0]  data_o,
  output logic             data_oe_o,
  output logic             irq_o,
  // modem pins, active low
  input  wire logic        cts_n_i,
  input  wire logic        dsr_n_i,
  input  wire logic        ri_n_i,
  input  wire logic        cd_n_i,
  output logic             dtr_n_o,
  output logic             rts_n_o,
  // receive shifter side
  input  wire logic [7:0]  rx_char_i,
  input  wire logic        rx_valid_i,
  // transmit shifter side
  output logic [7:0]       tx_char_o,
  output logic             tx_valid_o,
  input  wire logic        tx_taken_i,
  input  wire logic        tx_idle_i,
  output logic             rate_tick_o,
  // line setup for the shifters and flow control
  output logic [7:0]       line_format_o,
  output logic             loopback_o,
  output logic [7:0]       enh_feature_o,
  output logic [31:0]      flow_chars_o
);

  // pin synchronisers
  logic [16:0] pin_raw;
  logic [16:0] sync1_q;
  logic [16:0] sync2_q;
  logic [1:0]  strobe_prev_q;
  logic [3:0]  modem_prev_q;

  assign pin_raw = {~cd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i,
                    data_i, addr_i, ~(cs_n_i | rd_n_i), ~(cs_n_i | wr_n_i)};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  logic       rd_act;
  logic       wr_act;
  logic [2:0] bus_addr;
  byte_type   bus_data;
  logic [3:0] modem_in;
  logic       rd_start;
  logic       rd_end;
  logic       wr_start;

  assign wr_act   = sync2_q[0];
  assign rd_act   = sync2_q[1];
  assign bus_addr = sync2_q[4:2];
  assign bus_data = sync2_q[12:5];
  assign modem_in = sync2_q[16:13];
  assign rd_start = rd_act & ~strobe_prev_q[1];
  assign rd_end   = ~rd_act & strobe_prev_q[1];
  assign wr_start = wr_act & ~strobe_prev_q[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_prev_q <= '0;
      modem_prev_q  <= '0;
    end else begin
      strobe_prev_q <= {rd_act, wr_act};
      modem_prev_q  <= modem_in;
    end
  end

  // control registers
  byte_type lcr_q;
  byte_type ier_q;
  byte_type fcr_q;
  byte_type mcr_q;
  byte_type spr_q;
  byte_type efr_q;
  byte_type dll_q;
  byte_type dlm_q;
  byte_type resume_char_one_q;
  byte_type resume_char_two_q;
  byte_type pause_char_one_q;
  byte_type pause_char_two_q;

  logic div_bank;
  logic enh_bank;
  logic enh_on;
  logic ident_sel;
  logic fifo_en;
  byte_type ier_wmask;
  byte_type fcr_wmask;
  byte_type mcr_wmask;

  assign div_bank  = lcr_q[`LCR_DIV_BIT];
  assign enh_bank  = (lcr_q == `LCR_ENH_VALUE);
  assign enh_on    = efr_q[`EFR_ENH_BIT];
  assign ident_sel = div_bank & (dll_q == `ZERO_DIV)
                   & (dlm_q == `ZERO_DIV);
  assign fifo_en   = fcr_q[`FCR_EN_BIT];
  // extended bits only take writes while the enhanced feature bit is set
  assign ier_wmask = enh_on ? (`IER_BASE_MASK | `IER_ENH_MASK)
                            : `IER_BASE_MASK;
  assign fcr_wmask = enh_on ? (`FCR_BASE_MASK | `FCR_ENH_MASK)
                            : `FCR_BASE_MASK;
  assign mcr_wmask = enh_on ? (`MCR_BASE_MASK | `MCR_ENH_MASK)
                            : `MCR_BASE_MASK;

  logic wr_data_reg;
  logic wr_fcr;

  assign wr_data_reg = wr_start & (bus_addr == `ADDR_DATA) & ~div_bank;
  // queue setup bits are ignored unless the same write keeps the enable set
  assign wr_fcr = wr_start & (bus_addr == `ADDR_STATUS) & ~enh_bank;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lcr_q   <= `RST_BYTE;
      ier_q   <= `RST_BYTE;
      fcr_q   <= `RST_BYTE;
      mcr_q   <= `RST_BYTE;
      spr_q   <= `RST_BYTE;
      efr_q   <= `RST_BYTE;
      dll_q   <= `RST_BYTE;
      dlm_q   <= `RST_BYTE;
      resume_char_one_q  <= `RST_BYTE;
      resume_char_two_q  <= `RST_BYTE;
      pause_char_one_q <= `RST_BYTE;
      pause_char_two_q <= `RST_BYTE;
    end else if (wr_start) begin
      unique case (bus_addr)
        `ADDR_DATA: begin
          if (div_bank) dll_q <= bus_data;
        end
        `ADDR_MASK: begin
          if (div_bank) dlm_q <= bus_data;
          else ier_q <= bus_data & ier_wmask;
        end
        `ADDR_STATUS: begin
          if (enh_bank) efr_q <= bus_data;
          else if (bus_data[`FCR_EN_BIT]) fcr_q <= bus_data & fcr_wmask;
          else fcr_q <= `RST_BYTE;
        end
        `ADDR_LINE_FMT: lcr_q <= bus_data;
        `ADDR_MODEM_CTL: begin
          if (enh_bank) resume_char_one_q <= bus_data;
          else mcr_q <= bus_data & mcr_wmask;
        end
        `ADDR_LINE_STAT: begin
          if (enh_bank) resume_char_two_q <= bus_data;
        end
        `ADDR_MODEM_STAT: begin
          if (enh_bank) pause_char_one_q <= bus_data;
        end
        `ADDR_SCRATCH: begin
          if (enh_bank) pause_char_two_q <= bus_data;
          else spr_q <= bus_data;
        end
      endcase
    end
  end

  // receive queue
  byte_type                rx_mem [`RX_DEPTH];
  logic [`RX_PTR_W-1:0]    rx_wp_q;
  logic [`RX_PTR_W-1:0]    rx_rp_q;
  logic [`RX_CNT_W-1:0]    rx_cnt_q;
  logic [`RX_CNT_W-1:0]    rx_cap;
  logic [`RX_CNT_W-1:0]    rx_trig;
  logic                    rx_flush;
  logic                    rx_push;
  logic                    rx_pop;
  logic                    rx_overrun_ev;
  logic                    pop_pend_q;

  // without the queue enabled it acts as a single holding byte
  assign rx_cap  = fifo_en ? `RX_FULL : `RX_ONE;
  assign rx_flush = wr_fcr & (~bus_data[`FCR_EN_BIT]
                  | bus_data[`FCR_RXRST_BIT]);
  assign rx_push  = rx_valid_i & (rx_cnt_q < rx_cap);
  assign rx_overrun_ev = rx_valid_i & (rx_cnt_q >= rx_cap);
  assign rx_pop   = rd_end & pop_pend_q & (rx_cnt_q != '0);

  always_comb begin
    unique case (fcr_q[`FCR_TRIG_MSB:`FCR_TRIG_LSB])
      2'h0: rx_trig = `TRIG_LEVEL_0;
      2'h1: rx_trig = `TRIG_LEVEL_1;
      2'h2: rx_trig = `TRIG_LEVEL_2;
      2'h3: rx_trig = `TRIG_LEVEL_3;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rx_push) rx_mem[rx_wp_q] <= rx_char_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_flush) begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= '0;
    end else begin
      if (rx_push) rx_wp_q <= rx_wp_q + 4'h1;
      if (rx_pop) rx_rp_q <= rx_rp_q + 4'h1;
      unique case ({rx_push, rx_pop})
        2'b10:   rx_cnt_q <= rx_cnt_q + `RX_ONE;
        2'b01:   rx_cnt_q <= rx_cnt_q - `RX_ONE;
        default: rx_cnt_q <= rx_cnt_q;
      endcase
    end
  end

  // transmit holding
  byte_type thr_q;
  logic     thr_full_q;
  logic     tx_flush;

  assign tx_flush = wr_fcr & bus_data[`FCR_EN_BIT]
                  & bus_data[`FCR_TXRST_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thr_q <= `RST_BYTE;
    end else if (wr_data_reg) begin
      thr_q <= bus_data;
    end
  end

  // a host write in the same cycle as the shifter takes wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thr_full_q <= 1'b0;
    end else if (wr_data_reg) begin
      thr_full_q <= 1'b1;
    end else if (tx_taken_i || tx_flush) begin
      thr_full_q <= 1'b0;
    end
  end

  // status flags
  logic       overrun_q;
  logic       txe_flag_q;
  logic [3:0] delta_q;
  logic       lsr_rd_q;
  logic       msr_rd_q;
  logic       isr_txe_rd_q;
  logic       txe_ev;

  assign txe_ev = (tx_taken_i & thr_full_q & ~wr_data_reg)
                | (wr_start & (bus_addr == `ADDR_MASK) & ~div_bank
                   & bus_data[`IER_TXE_BIT] & ~ier_q[`IER_TXE_BIT]
                   & ~thr_full_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overrun_q <= 1'b0;
    end else if (rx_overrun_ev) begin
      overrun_q <= 1'b1;
    end else if (rd_end && lsr_rd_q) begin
      overrun_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txe_flag_q <= 1'b0;
    end else if (txe_ev) begin
      txe_flag_q <= 1'b1;
    end else if (wr_data_reg || (rd_end && isr_txe_rd_q)) begin
      txe_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delta_q <= '0;
    end else begin
      delta_q <= ((rd_end && msr_rd_q) ? 4'h0 : delta_q)
               | (modem_in ^ modem_prev_q);
    end
  end

  // interrupt source selection
  logic           rx_level_hit;
  irq_source_type src;
  byte_type       isr_val;
  byte_type       lsr_val;
  byte_type       msr_val;

  // queue mode uses the trigger; single-byte mode any character
  assign rx_level_hit = fifo_en ? (rx_cnt_q >= rx_trig)
                                : (rx_cnt_q != '0);

  always_comb begin
    if (ier_q[`IER_RLS_BIT] && overrun_q) begin
      src = SRC_LINE;
    end else if (ier_q[`IER_RXD_BIT] && rx_level_hit) begin
      src = SRC_RXD;
    end else if (ier_q[`IER_TXE_BIT] && txe_flag_q) begin
      src = SRC_TXE;
    end else if (ier_q[`IER_MS_BIT] && (delta_q != '0)) begin
      src = SRC_MODEM;
    end else begin
      src = SRC_NONE;
    end
  end

  assign isr_val = {fifo_en, fifo_en, 2'b00, src};
  assign lsr_val = {1'b0, thr_full_q ? 1'b0 : tx_idle_i, ~thr_full_q,
                    3'b000, overrun_q, rx_cnt_q != '0};
  assign msr_val = {modem_in[3], modem_in[2], modem_in[1], modem_in[0],
                    delta_q[3], delta_q[2], delta_q[1], delta_q[0]};

  // read path
  byte_type rd_mux;
  byte_type rd_data_q;
  logic     rd_oe_q;

  always_comb begin
    unique case (bus_addr)
      `ADDR_DATA: begin
        if (ident_sel) rd_mux = REV_CODE;
        else if (div_bank) rd_mux = dll_q;
        else rd_mux = rx_mem[rx_rp_q];
      end
      `ADDR_MASK: begin
        if (ident_sel) rd_mux = IDENT_CODE;
        else if (div_bank) rd_mux = dlm_q;
        else rd_mux = ier_q;
      end
      `ADDR_STATUS:     rd_mux = enh_bank ? efr_q : isr_val;
      `ADDR_LINE_FMT:   rd_mux = lcr_q;
      `ADDR_MODEM_CTL:  rd_mux = enh_bank ? `RST_BYTE : mcr_q;
      `ADDR_LINE_STAT:  rd_mux = lsr_val;
      `ADDR_MODEM_STAT: rd_mux = msr_val;
      `ADDR_SCRATCH:    rd_mux = enh_bank ? `RST_BYTE : spr_q;
    endcase
  end

  // data and side effects are fixed at the start of the read strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_q    <= `RST_BYTE;
      rd_oe_q      <= 1'b0;
      pop_pend_q   <= 1'b0;
      lsr_rd_q     <= 1'b0;
      msr_rd_q     <= 1'b0;
      isr_txe_rd_q <= 1'b0;
    end else if (rd_start) begin
      rd_data_q    <= rd_mux;
      rd_oe_q      <= 1'b1;
      pop_pend_q   <= (bus_addr == `ADDR_DATA) & ~div_bank;
      lsr_rd_q     <= (bus_addr == `ADDR_LINE_STAT);
      msr_rd_q     <= (bus_addr == `ADDR_MODEM_STAT);
      isr_txe_rd_q <= (bus_addr == `ADDR_STATUS) & ~enh_bank
                    & (src == SRC_TXE);
    end else if (rd_end) begin
      rd_oe_q      <= 1'b0;
      pop_pend_q   <= 1'b0;
      lsr_rd_q     <= 1'b0;
      msr_rd_q     <= 1'b0;
      isr_txe_rd_q <= 1'b0;
    end
  end

  // rate generator
  rate_if rate ();

  assign rate.divisor = {dlm_q, dll_q};

  rate_generator u_rate (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .rate  (rate)
  );

  // outputs
  assign data_o        = rd_data_q;
  assign data_oe_o     = rd_oe_q;
  assign irq_o         = (src != SRC_NONE);
  assign dtr_n_o       = ~mcr_q[`MCR_DTR_BIT];
  assign rts_n_o       = ~mcr_q[`MCR_RTS_BIT];
  assign tx_char_o     = thr_q;
  assign tx_valid_o    = thr_full_q;
  assign rate_tick_o   = rate.tick;
  assign line_format_o = lcr_q;
  assign loopback_o    = mcr_q[`MCR_LOOP_BIT];
  assign enh_feature_o = efr_q;
  assign flow_chars_o  = {pause_char_two_q, pause_char_one_q, resume_char_two_q, resume_char_one_q};

endmodule

`default_nettype wire

/* File: sim/host_bus_model.sv */
// host processor model driving the parallel register bus pins
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
  // clock
  input  wire logic       clk_i,
  // bus pins toward the port
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic [2:0]      addr_o,
  output logic [7:0]      wdata_o,
  input  wire logic [7:0] rdata_i
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 3'h0;
    wdata_o = 8'h00;
  end

  // address settles two cycles early: the port samples pins through two flops
  task automatic setup(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    repeat (2) @(posedge clk_i);
    #1;
    cs_n_o = 1'b0;
  endtask

  // released data lines flip so a stale value is never mistaken for data
  task automatic strobes_off;
    #1;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    wdata_o = ~wdata_o;
    repeat (5) @(posedge clk_i);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    setup(a, d);
    wr_n_o = 1'b0;
    repeat (5) @(posedge clk_i);
    strobes_off();
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    setup(a, ~wdata_o);
    rd_n_o = 1'b0;
    repeat (5) @(posedge clk_i);
    d = rdata_i;
    strobes_off();
  endtask
endmodule

`default_nettype wire

/* File: sim/uart_regs_sva.sv */
// assertion checker for the serial port register file pins
`timescale 1ns/1ps
`default_nettype none

module uart_regs_sva (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // host bus
  input wire logic        cs_n_i,
  input wire logic        rd_n_i,
  input wire logic        wr_n_i,
  input wire logic [2:0]  addr_i,
  input wire logic [7:0]  data_o,
  input wire logic        data_oe_o,
  input wire logic        irq_o,
  // pins and setup outputs
  input wire logic        dtr_n_o,
  input wire logic        rts_n_o,
  input wire logic [7:0]  tx_char_o,
  input wire logic        tx_valid_o,
  input wire logic        tx_taken_i,
  input wire logic        rate_tick_o,
  input wire logic [7:0]  line_format_o,
  input wire logic [7:0]  enh_feature_o,
  input wire logic [31:0] flow_chars_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic wr_on;
  logic wr_seen_q;
  assign wr_on = !cs_n_i && !wr_n_i;

  // divisor is zero until the first write, so no tick may appear before it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_seen_q <= 1'b0;
    end else if (wr_on) begin
      wr_seen_q <= 1'b1;
    end
  end

  sequence rd_held;
    (!cs_n_i && !rd_n_i) [*4];
  endsequence

  sequence rd_gone;
    rd_n_i [*4];
  endsequence

  a_reset_state: assert property (disable iff (1'b0)
    rst_i |=> dtr_n_o && rts_n_o && !data_oe_o && !irq_o && !tx_valid_o)
    else $error("outputs not idle after reset");
  a_read_drives: assert property (
    rd_held |-> data_oe_o) else $error("read data not driven");
  a_drive_cause: assert property (
    $rose(data_oe_o) |-> !cs_n_i && !rd_n_i)
    else $error("bus driven without a read");
  a_drive_ends: assert property (
    rd_gone |-> !data_oe_o) else $error("bus still driven after read");
  a_read_stable: assert property (
    data_oe_o && $past(data_oe_o) |-> $stable(data_o))
    else $error("read data changed while driven");
  a_setup_by_write: assert property (
    $changed({line_format_o, enh_feature_o, flow_chars_o, tx_char_o,
              dtr_n_o, rts_n_o}) |-> wr_on)
    else $error("setup output changed without a write");
  a_tx_load: assert property (
    $rose(tx_valid_o) |-> wr_on && addr_i == 3'h0)
    else $error("transmit holding filled without data write");
  a_tx_drain: assert property (
    $fell(tx_valid_o) |-> $past(tx_taken_i) || wr_on)
    else $error("transmit holding emptied without cause");
  a_tick_idle: assert property (
    !wr_seen_q |-> !rate_tick_o) else $error("rate tick with zero divisor");
endmodule

bind uart_regs_top uart_regs_sva chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i),
  .wr_n_i(wr_n_i), .addr_i(addr_i), .data_o(data_o),
  .data_oe_o(data_oe_o), .irq_o(irq_o), .dtr_n_o(dtr_n_o),
  .rts_n_o(rts_n_o), .tx_char_o(tx_char_o), .tx_valid_o(tx_valid_o),
  .tx_taken_i(tx_taken_i), .rate_tick_o(rate_tick_o),
  .line_format_o(line_format_o), .enh_feature_o(enh_feature_o),
  .flow_chars_o(flow_chars_o)
);

`default_nettype wire

/* File: sim/uart_regs_top_tb.sv */
// self-checking bench for the serial port register file
`timescale 1ns/1ps
`default_nettype none

module uart_regs_top_tb;
  import uart_regs_pkg::*;
  localparam byte_type REV = 8'h71; // arbitrary value
  localparam byte_type IDN = 8'h2e; // arbitrary value
  logic        clk_i, rst_i, cs_n, rd_n, wr_n, oe, irq, dtr_n, rts_n;
  logic        rx_valid, tx_valid, tx_taken, tx_idle, tick, loopback, cts_n;
  logic [2:0]  addr;
  logic [7:0]  wdata, dout, rx_char, tx_char, line_fmt, enh;
  logic [31:0] flow;
  int          errors, samples_checked, cyc, n, i;

  uart_regs_top #(.REV_CODE(REV), .IDENT_CODE(IDN)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .addr_i(addr), .data_i(wdata), .data_o(dout),
    .data_oe_o(oe), .irq_o(irq), .cts_n_i(cts_n), .dsr_n_i(1'b1),
    .ri_n_i(1'b1), .cd_n_i(1'b1), .dtr_n_o(dtr_n), .rts_n_o(rts_n),
    .rx_char_i(rx_char), .rx_valid_i(rx_valid), .tx_char_o(tx_char),
    .tx_valid_o(tx_valid), .tx_taken_i(tx_taken), .tx_idle_i(tx_idle),
    .rate_tick_o(tick), .line_format_o(line_fmt), .loopback_o(loopback),
    .enh_feature_o(enh), .flow_chars_o(flow));

  host_bus_model hm (.clk_i(clk_i), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata), .rdata_i(dout));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    hm.rd(a, v);
    chk(v, e);
  endtask

  task automatic push(input byte_type c);
    @(posedge clk_i);
    #1;
    rx_char = c;
    rx_valid = 1'b1;
    @(posedge clk_i);
    #1;
    rx_valid = 1'b0;
  endtask

  // cycles from one rate tick to the next, bounded against a dead counter
  task automatic tick_gap(output int g);
    int w;
    w = 0;
    do begin @(negedge clk_i); w++; end while (!tick && w < 600);
    g = 0;
    do begin @(negedge clk_i); g++; end while (!tick && g < 600);
  endtask

  task automatic close_out;
    $display("errors %0d of %0d checks", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    rst_i = 1'b1;
    rx_char = 8'h00;
    rx_valid = 1'b0;
    tx_taken = 1'b0;
    tx_idle = 1'b1;
    cts_n = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    rdc(3'h2, 8'h01);
    rdc(3'h5, 8'h60);
    hm.wr(3'h3, 8'h80);
    rdc(3'h0, REV);
    rdc(3'h1, IDN);
    hm.wr(3'h0, 8'h02);
    hm.wr(3'h1, 8'h01);
    rdc(3'h0, 8'h02);
    rdc(3'h1, 8'h01);
    chk(tx_valid, 1'b0);
    tick_gap(n);
    tick_gap(n);
    chk(n, 258);
    hm.wr(3'h3, 8'h03);
    rdc(3'h1, 8'h00);
    hm.wr(3'h7, 8'h5a);
    hm.wr(3'h1, 8'hf6);
    rdc(3'h1, 8'h06);
    chk(irq, 1'b1);
    rdc(3'h2, 8'h02);
    rdc(3'h2, 8'h01);
    chk(irq, 1'b0);
    hm.wr(3'h1, 8'h00);
    hm.wr(3'h2, 8'h41);
    for (i = 0; i < 4; i++) push(byte_type'(8'h10 + i));
    chk(irq, 1'b0);
    rdc(3'h2, 8'hc1);
    rdc(3'h5, 8'h61);
    hm.wr(3'h1, 8'h01);
    chk(irq, 1'b1);
    rdc(3'h2, 8'hc4);
    rdc(3'h0, 8'h10);
    chk(irq, 1'b0);
    rdc(3'h2, 8'hc1);
    push(8'h14);
    chk(irq, 1'b1);
    for (i = 1; i < 5; i++) rdc(3'h0, byte_type'(8'h10 + i));
    rdc(3'h5, 8'h60);
    hm.wr(3'h0, 8'ha5);
    chk(tx_valid, 1'b1);
    chk(tx_char, 8'ha5);
    rdc(3'h5, 8'h00);
    @(posedge clk_i);
    #1;
    tx_taken = 1'b1;
    @(posedge clk_i);
    #1;
    tx_taken = 1'b0;
    chk(tx_valid, 1'b0);
    hm.wr(3'h3, 8'hbf);
    hm.wr(3'h2, 8'h10);
    chk(enh, 8'h10);
    rdc(3'h2, 8'h10);
    for (i = 0; i < 4; i++) hm.wr(3'(4 + i), 8'(8'h11 * (i + 1)));
    chk(flow, 32'h44332211);
    rdc(3'h4, 8'h00);
    hm.wr(3'h3, 8'h03);
    rdc(3'h7, 8'h5a);
    hm.wr(3'h1, 8'hf1);
    rdc(3'h1, 8'hf1);
    hm.wr(3'h4, 8'hf7);
    rdc(3'h4, 8'hf7);
    chk({loopback, dtr_n, rts_n}, 3'b100);
    chk(line_fmt, 8'h03);
    chk(oe, 1'b0);
    // line status source: overrun of the full queue
    hm.wr(3'h1, 8'h04);
    for (i = 0; i < 17; i++) push(8'h00);
    chk(irq, 1'b1);
    rdc(3'h2, 8'hc6);
    rdc(3'h5, 8'h63);
    chk(irq, 1'b0);
    // modem source: one clear-to-send change
    hm.wr(3'h1, 8'h08);
    chk(irq, 1'b0);
    @(posedge clk_i);
    #1;
    cts_n = 1'b0;
    repeat (4) @(posedge clk_i);
    chk(irq, 1'b1);
    rdc(3'h2, 8'hc0);
    rdc(3'h6, 8'h11);
    chk(irq, 1'b0);
    rdc(3'h6, 8'h10);
    close_out();
  end
endmodule

`default_nettype wire
